// File: src/pvc_pkg.sv
// package of constants for the vendor page and self-id configuration block
package pvc_pkg;
	// register index (4-bit phy register address)
	localparam logic [3:0] PVC_REG_PWR = 4'h4;
	localparam logic [3:0] PVC_REG_PAGE = 4'h7;
	localparam logic [3:0] PVC_REG_VCFG = 4'h8;
	// page select field
	localparam logic [2:0] PVC_PAGE_VENDOR = 3'h7;
	localparam logic [2:0] PVC_PAGE_RST = 3'h0;
	// vendor config register field positions (lsb-first, bit 0 = data bit 0)
	localparam int PVC_NPA_BIT = 7;
	localparam int PVC_SPD_LSB = 0;
	// power register: power class in low three bits
	localparam int PVC_PWR_LSB = 0;
	// link speed codes
	localparam logic [1:0] PVC_SPD_S100 = 2'h0;
	localparam logic [1:0] PVC_SPD_S200 = 2'h1;
	localparam logic [1:0] PVC_SPD_S400 = 2'h2;
	localparam logic [1:0] PVC_SPD_ILLEGAL = 2'h3;
	localparam logic [1:0] PVC_SPD_RST = PVC_SPD_S400;
	localparam logic PVC_NPA_RST = 1'b0;
	// peer-facing speed signalling code, fixed
	localparam logic [1:0] PVC_PEER_SPD = PVC_SPD_S400;
	// packet length threshold in data bits
	localparam logic [15:0] PVC_ACK_BITS = 16'h0008;
	// self-id field positions (bit 0 = msb of 32-bit packet)
	localparam int PVC_SID_SP_HI = 14;
	localparam int PVC_SID_PWR_HI = 21;
	localparam int PVC_SID_PWR_LO = 23;
endpackage

// File: src/pvc_core.sv
// vendor page config, link speed and power class logic
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pvc_core
	import pvc_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic [2:0] power_class_strap_pins_in,
	input wire logic bus_reset_in,
	input wire logic arb_accel_en_in,
	input wire logic pkt_end_in,
	input wire logic [15:0] pkt_bits_in,
	input wire logic pend_req_in,
	output logic pend_req_out,
	output logic [1:0] sid_speed_out,
	output logic [2:0] sid_pwr_out,
	output logic [1:0] peer_speed_out,
	output logic null_packet_action_flag_out
);
	// ==========================================================
	// register state
	logic null_packet_action_flag_r;
	logic [1:0] attached_link_top_speed_r;
	logic [2:0] pwr_class_r;
	logic [2:0] page_sel_r;
	logic strap_done_r;
	logic vendor_sel;
	logic [7:0] rdata_nxt;

	assign vendor_sel = (page_sel_r == PVC_PAGE_VENDOR);

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			page_sel_r <= PVC_PAGE_RST;
		end else if (reg_wr_in && reg_addr_in == PVC_REG_PAGE) begin
			page_sel_r <= reg_wdata_in[7:5];
		end
	end

	// flag and speed: hardware reset only, bus reset ignored
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			null_packet_action_flag_r <= PVC_NPA_RST;
			attached_link_top_speed_r <= PVC_SPD_RST;
		end else if (reg_wr_in && vendor_sel && reg_addr_in == PVC_REG_VCFG) begin
			null_packet_action_flag_r <= reg_wdata_in[PVC_NPA_BIT];
			attached_link_top_speed_r <= reg_wdata_in[PVC_SPD_LSB +: 2];
		end
	end

	// power class: strap after reset release, then software
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pwr_class_r <= 3'h0;
			strap_done_r <= 1'b0;
		end else if (!strap_done_r) begin
			pwr_class_r <= power_class_strap_pins_in;
			strap_done_r <= 1'b1;
		end else if (reg_wr_in && reg_addr_in == PVC_REG_PWR) begin
			pwr_class_r <= reg_wdata_in[PVC_PWR_LSB +: 3];
		end
	end

	// ==========================================================
	// read port
	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_addr_in == PVC_REG_PAGE) begin
			rdata_nxt = {page_sel_r, 5'h00};
		end else if (reg_addr_in == PVC_REG_PWR) begin
			rdata_nxt = {5'h00, pwr_class_r};
		end else if (vendor_sel && reg_addr_in == PVC_REG_VCFG) begin
			rdata_nxt[PVC_NPA_BIT] = null_packet_action_flag_r;
			rdata_nxt[PVC_SPD_LSB +: 2] = attached_link_top_speed_r;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			reg_rdata_out <= rdata_nxt;
		end else begin
			reg_rdata_out <= 8'h00;
		end
	end

	// ==========================================================
	// pending request clearing
	logic clr_req;
	always_comb begin
		clr_req = 1'b0;
		if (pkt_end_in) begin
			if (null_packet_action_flag_r && arb_accel_en_in) begin
				clr_req = (pkt_bits_in > PVC_ACK_BITS);
			end else begin
				clr_req = (pkt_bits_in != PVC_ACK_BITS);
			end
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pend_req_out <= 1'b0;
		end else if (bus_reset_in) begin
			pend_req_out <= 1'b0;
		end else if (pend_req_in) begin
			pend_req_out <= 1'b1;
		end else if (clr_req) begin
			pend_req_out <= 1'b0;
		end
	end

	// ==========================================================
	// self-id fields
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sid_speed_out <= PVC_SPD_RST;
			sid_pwr_out <= 3'h0;
			peer_speed_out <= PVC_PEER_SPD;
			null_packet_action_flag_out <= PVC_NPA_RST;
		end else begin
			sid_speed_out <= attached_link_top_speed_r;
			sid_pwr_out <= pwr_class_r;
			peer_speed_out <= PVC_PEER_SPD;
			null_packet_action_flag_out <= null_packet_action_flag_r;
		end
	end

	// ==========================================================
	// elaboration checks on field placement
	if (PVC_NPA_BIT > 7 || PVC_NPA_BIT < 2) begin : g_npa_pos_check
		$error("flag bit outside the data byte");
	end

	if (PVC_SPD_LSB > 6) begin : g_spd_pos_check
		$error("speed field outside the data byte");
	end

	if (PVC_PWR_LSB > 5) begin : g_pwr_pos_check
		$error("power class outside the data byte");
	end

	// ==========================================================
	// checks: self-id fields
	chk_peer_fixed: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		peer_speed_out == PVC_PEER_SPD) else $error("peer speed not S400");

	chk_sid_speed: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		##1 sid_speed_out == $past(attached_link_top_speed_r)) else $error("sp field mismatch");

	chk_sid_pwr: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		##1 sid_pwr_out == $past(pwr_class_r)) else $error("pwr field mismatch");

	chk_flag_copy: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		##1 null_packet_action_flag_out == $past(null_packet_action_flag_r))
		else $error("flag output mismatch");

	// ==========================================================
	// checks: pending request clearing
	chk_npa_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		pend_req_out && !pend_req_in && !bus_reset_in && pkt_end_in && null_packet_action_flag_r
		&& arb_accel_en_in && pkt_bits_in <= PVC_ACK_BITS |=> pend_req_out) else $error("short packet cleared");

	chk_npa_long: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		!pend_req_in && pkt_end_in && null_packet_action_flag_r && arb_accel_en_in
		&& pkt_bits_in > PVC_ACK_BITS
		|=> !pend_req_out) else $error("long packet did not clear");

	chk_nonack_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		!pend_req_in && pkt_end_in && !null_packet_action_flag_r && pkt_bits_in != PVC_ACK_BITS
		|=> !pend_req_out) else $error("non-ack did not clear");

	chk_ack_keep: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		pend_req_out && !bus_reset_in && pkt_end_in && pkt_bits_in == PVC_ACK_BITS
		|=> pend_req_out) else $error("ack cleared request");

	chk_pend_set: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		pend_req_in && !bus_reset_in
		|=> pend_req_out) else $error("request not held pending");

	chk_pend_idle: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		pend_req_out && !pkt_end_in && !bus_reset_in
		|=> pend_req_out) else $error("request dropped without packet");

	chk_busrst_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		bus_reset_in
		|=> !pend_req_out) else $error("bus reset kept request");

	// ==========================================================
	// checks: vendor page register
	chk_vcfg_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		reg_wr_in && reg_addr_in == PVC_REG_VCFG && !vendor_sel
		|=> $stable(attached_link_top_speed_r) && $stable(null_packet_action_flag_r)) else $error("wrong page wrote");

	chk_flag_take: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		reg_wr_in && vendor_sel && reg_addr_in == PVC_REG_VCFG
		|=> null_packet_action_flag_r == $past(reg_wdata_in[PVC_NPA_BIT]))
		else $error("flag write lost");

	chk_speed_take: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		reg_wr_in && vendor_sel && reg_addr_in == PVC_REG_VCFG
		|=> attached_link_top_speed_r == $past(reg_wdata_in[1:0]))
		else $error("speed write lost");

	chk_flag_busrst: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		bus_reset_in && !(reg_wr_in && reg_addr_in == PVC_REG_VCFG)
		|=> $stable(null_packet_action_flag_r)) else $error("bus reset changed flag");

	chk_speed_busrst: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		bus_reset_in && !(reg_wr_in && reg_addr_in == PVC_REG_VCFG)
		|=> $stable(attached_link_top_speed_r)) else $error("bus reset changed speed");

	chk_page_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		reg_wr_in && reg_addr_in == PVC_REG_PAGE
		|=> page_sel_r == $past(reg_wdata_in[7:5])) else $error("page select lost");

	chk_vcfg_hidden: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		reg_rd_in && reg_addr_in == PVC_REG_VCFG && !vendor_sel
		|=> reg_rdata_out == 8'h00) else $error("vendor reg seen off page");

	chk_rsvd_zero: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		reg_rd_in && reg_addr_in == PVC_REG_VCFG |=> reg_rdata_out[6:2] == 5'h00) else $error("reserved bits set");

	chk_rdata_idle: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		!reg_rd_in
		|=> reg_rdata_out == 8'h00) else $error("read data outside read");

	// ==========================================================
	// checks: power class
	chk_strap_load: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$rose(strap_done_r)
		|-> pwr_class_r == $past(power_class_strap_pins_in)) else $error("strap not loaded");

	chk_pwr_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		strap_done_r && reg_wr_in && reg_addr_in == PVC_REG_PWR
		|=> ##1 sid_pwr_out == $past(reg_wdata_in[2:0], 2)) else $error("pwr write lost");

	chk_pwr_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		strap_done_r && !(reg_wr_in && reg_addr_in == PVC_REG_PWR)
		|=> $stable(pwr_class_r)) else $error("power class changed");

	chk_pwr_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		reg_rd_in && reg_addr_in == PVC_REG_PWR
		|=> reg_rdata_out == {5'h00, $past(pwr_class_r)}) else $error("power class read wrong");

	// ==========================================================
	// main scenarios
	cov_vendor_write: cover property (@(posedge clk_in) disable iff (!reset_n_in)
		reg_wr_in && vendor_sel && reg_addr_in == PVC_REG_VCFG);

	cov_npa_hold: cover property (@(posedge clk_in) disable iff (!reset_n_in)
		pkt_end_in && null_packet_action_flag_r && arb_accel_en_in && pkt_bits_in == 16'h0000);

	cov_pwr_override: cover property (@(posedge clk_in) disable iff (!reset_n_in)
		strap_done_r && reg_wr_in && reg_addr_in == PVC_REG_PWR);

	cov_long_clear: cover property (@(posedge clk_in) disable iff (!reset_n_in)
		pend_req_out && pkt_end_in && null_packet_action_flag_r && pkt_bits_in > PVC_ACK_BITS);

	cov_busrst_kept: cover property (@(posedge clk_in) disable iff (!reset_n_in)
		bus_reset_in && null_packet_action_flag_r);
endmodule
`default_nettype wire

// File: testbench/pvc_link_model.sv
// link-layer model driving the phy register port
`timescale 1ns/1ps
`default_nettype none
module pvc_link_model
	import pvc_pkg::*;
(
	input wire logic clk_in,
	input wire logic [7:0] reg_rdata_in,
	output logic [3:0] reg_addr_out,
	output logic [7:0] reg_wdata_out,
	output logic reg_wr_out,
	output logic reg_rd_out
);
	// ==========
	// bus cycles
	initial begin
		reg_addr_out = 4'h0;
		reg_wdata_out = 8'h00;
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		reg_addr_out <= a;
		reg_wdata_out <= d;
		reg_wr_out <= 1'b1;
		@(posedge clk_in);
		reg_wr_out <= 1'b0;
		reg_wdata_out <= ~d;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_in);
		reg_addr_out <= a;
		reg_rd_out <= 1'b1;
		@(posedge clk_in);
		reg_rd_out <= 1'b0;
		#1 d = reg_rdata_in;
	endtask
	// vendor page config, never sends speed code 11
	task automatic vcfg(input logic f, input logic [1:0] s);
		wr(PVC_REG_PAGE, {PVC_PAGE_VENDOR, 5'h00});
		wr(PVC_REG_VCFG, {f, 5'h00, (s == PVC_SPD_ILLEGAL) ? PVC_SPD_S400 : s});
	endtask
endmodule
`default_nettype wire

// File: testbench/phy_vendor_page_selfid_config_tb.sv
// self-checking bench for the vendor page config block
`timescale 1ns/1ps
`default_nettype none
module phy_vendor_page_selfid_config_tb
	import pvc_pkg::*;
;
	logic clk = 1'b0, rst_n = 1'b0, bus_rst = 1'b0, accel = 1'b0, pend_in = 1'b0, pkt_end = 1'b0;
	logic [2:0] strap = 3'h5;
	logic [15:0] bits = 16'h0000;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, d;
	logic wr, rd, pend_out, flag;
	logic [1:0] sid_spd, peer;
	logic [2:0] sid_pwr;
	int bad_count = 0, comparisons = 0, cyc = 0;
	logic [18:0] rows [9] = '{{3'b010, 16'h0000}, {3'b011, 16'h0008}, {3'b010, 16'h0005},
		{3'b010, 16'h0009}, {3'b111, 16'h0000}, {3'b111, 16'h0008}, {3'b110, 16'h0009},
		{3'b110, 16'hFFFF}, {3'b100, 16'h0000}};
	always #25 clk = ~clk;
	pvc_link_model lnk(.clk_in(clk), .reg_rdata_in(rdata), .reg_addr_out(addr), .reg_wdata_out(wdata),
		.reg_wr_out(wr), .reg_rd_out(rd));
	pvc_core dut(.clk_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdata), .power_class_strap_pins_in(strap), .bus_reset_in(bus_rst),
		.arb_accel_en_in(accel), .pkt_end_in(pkt_end), .pkt_bits_in(bits), .pend_req_in(pend_in),
		.pend_req_out(pend_out), .sid_speed_out(sid_spd), .sid_pwr_out(sid_pwr), .peer_speed_out(peer),
		.null_packet_action_flag_out(flag));
	// ==========
	// checks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			end_sim();
		end
	end
	// ==========
	// sequence
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk({5'h00, sid_pwr}, 8'h05);
		chk({6'h00, peer}, {6'h00, PVC_PEER_SPD});
		lnk.rd(PVC_REG_VCFG, d);
		chk(d, 8'h00);
		lnk.wr(PVC_REG_PAGE, 8'hE0);
		lnk.rd(PVC_REG_VCFG, d);
		chk(d, 8'h02);
		for (int c = 0; c < 8; c++) begin
			lnk.wr(PVC_REG_PWR, 8'(c));
			@(posedge clk);
			#1 chk({5'h00, sid_pwr}, 8'(c));
		end
		foreach (rows[i]) begin
			lnk.vcfg(rows[i][18], PVC_SPD_S200);
			accel <= rows[i][17];
			@(posedge clk);
			#1 chk({6'h00, sid_spd}, 8'h01);
			@(posedge clk) pend_in <= 1'b1;
			@(posedge clk) pend_in <= 1'b0;
			pkt_end <= 1'b1;
			bits <= rows[i][15:0];
			@(posedge clk) pkt_end <= 1'b0;
			#1 chk({7'h00, pend_out}, {7'h00, rows[i][16]});
		end
		@(posedge clk) bus_rst <= 1'b1;
		@(posedge clk) bus_rst <= 1'b0;
		lnk.rd(PVC_REG_VCFG, d);
		chk(d, 8'h81);
		lnk.wr(PVC_REG_VCFG, 8'h7D);
		lnk.rd(PVC_REG_VCFG, d);
		chk(d, 8'h01);
		lnk.rd(4'hF, d);
		chk(d, 8'h00);
		lnk.wr(PVC_REG_VCFG, 8'h81);
		@(posedge clk) rst_n <= 1'b0;
		strap <= 3'h2;
		@(posedge clk) rst_n <= 1'b1;
		@(posedge clk);
		lnk.wr(PVC_REG_VCFG, 8'h81);
		lnk.wr(PVC_REG_PAGE, 8'hE0);
		lnk.rd(PVC_REG_VCFG, d);
		chk(d, 8'h02);
		chk({4'h0, sid_pwr, flag}, 8'h04);
		end_sim();
	end
endmodule
`default_nettype wire
